// ---- hw/pcs_sequencer.sv ----
// Commissioning action sequencer with AXI4-Lite register slave.
// Assumes all inputs synchronous to clk; power_up marks a controller power cycle.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Enter mode at power-up if enable set
// - Report mode value 2 while commissioning
// - Leave mode at power-up once enable 0
// - Start selected action when command becomes 1
// - Level 0 while supply fault active
// - Level 1 other severe error, else 2
// - Status shows denied and in progress
// - Deny action needing higher permission level
// - Deny bad stroke count or config index
// - Short actions show in progress briefly; config change goes straight to done
// - Fire energizes masked coils at level 1-2
// - Pump masked coils, 1 to 100 strokes
// - Pump needs shaft speed and level 2
// - Config change stores new config index
// - Config change allowed at every level
// - Types 4-6 run raw displacement per output
// - Raw displacement uses stored config index
// - Raw needs shaft speed and level 2
// - Mask bits map groups A, B, C
// - Mask is plain unsigned integer 0..4095
module pcs_sequencer
   import pcs_pkg::*;
#(
   parameter int NUM_SERVICES = 3,
   parameter int NUM_CONFIGS = 4,
   parameter int FIRE_CYCLES = PCS_FIRE_CYCLES
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic power_up,
   input wire logic supply_fault_error,
   input wire logic severe_error,
   input wire logic shaft_speed_low_error,
   input wire logic stroke_angle,
   output logic commissioning_mode,
   output logic [11:0] coil_drive,
   output logic [2:0] raw_service_active,
   output logic [15:0] output1_displacement_reference,
   output logic [7:0] current_config_index
);
   // ==========================================================
   // Elaboration checks
   if (NUM_SERVICES < 1 || NUM_SERVICES > 3) begin : g_bad_services
      $error("NUM_SERVICES must be 1 to 3");
   end
   if (NUM_CONFIGS < 1 || NUM_CONFIGS > 256 || FIRE_CYCLES < 1 || FIRE_CYCLES > 65535) begin : g_bad_counts
      $error("NUM_CONFIGS or FIRE_CYCLES out of range");
   end

   // ==========================================================
   // Functions
   function automatic logic reg_known(input logic [7:0] a);
      return a[1:0] == 2'h0 && a <= PCS_REG_CONFIG_SRC;
   endfunction : reg_known

   // Bit g*4+u of the mask drives coil g+3u (0-based)
   function automatic logic [11:0] coil_map(input logic [11:0] m);
      logic [11:0] c;
      c = '0;
      for (int g = 0; g < PCS_GROUPS; g++) begin
         for (int u = 0; u < PCS_UNITS; u++) begin
            c[u * PCS_GROUPS + g] = m[g * PCS_UNITS + u];
         end
      end
      return c;
   endfunction : coil_map

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b * 8 +: 8] = d[b * 8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // ==========================================================
   // AXI4-Lite write channel
   logic aw_full_q, w_full_q;
   logic [7:0] waddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic aw_hs, w_hs, b_hs, do_write, aw_full_d, w_full_d;
   assign aw_hs = s_axi_awvalid & s_axi_awready;
   assign w_hs = s_axi_wvalid & s_axi_wready;
   assign b_hs = s_axi_bvalid & s_axi_bready;
   assign do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
   assign aw_full_d = (aw_full_q | aw_hs) & ~b_hs;
   assign w_full_d = (w_full_q | w_hs) & ~b_hs;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         waddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else begin
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         s_axi_awready <= ~aw_full_d;
         s_axi_wready <= ~w_full_d;
         if (aw_hs) begin
            waddr_q <= s_axi_awaddr;
         end
         if (w_hs) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= PCS_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= reg_known(waddr_q) ? PCS_RESP_OKAY : PCS_RESP_SLVERR;
      end else if (b_hs) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Software-written registers
   logic enable_q, command_q, config_src_q;
   pcs_request_type req_q;
   logic [31:0] wmerged;
   assign wmerged = merge(PCS_RESET_WORD, wdata_q, wstrb_q);
   logic [31:0] mask_merged, value_merged;
   assign mask_merged = merge({20'h0, req_q.mask}, wdata_q, wstrb_q);
   assign value_merged = merge({16'h0, req_q.value}, wdata_q, wstrb_q);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         enable_q <= 1'b0;
         command_q <= 1'b0;
         config_src_q <= 1'b0;
         req_q <= '0;
      end else if (do_write && wstrb_q != 4'h0) begin
         // Unwritten byte lanes keep their old contents
         case (waddr_q)
            PCS_REG_ENABLE: if (wstrb_q[0]) enable_q <= wmerged[0];
            PCS_REG_ACTION: if (wstrb_q[0]) req_q.kind <= wmerged[2:0];
            PCS_REG_MASK: req_q.mask <= mask_merged[11:0];
            PCS_REG_VALUE: req_q.value <= value_merged[15:0];
            PCS_REG_COMMAND: if (wstrb_q[0]) command_q <= wmerged[0];
            PCS_REG_CONFIG_SRC: if (wstrb_q[0]) config_src_q <= wmerged[0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Mode and permission level
   logic [1:0] level_q, mode_q;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         commissioning_mode <= 1'b0;
         mode_q <= PCS_MODE_NORMAL;
      end else if (power_up) begin
         // Enable only counts at power-up, never while running
         commissioning_mode <= enable_q;
         mode_q <= enable_q ? PCS_MODE_COMMISSION : PCS_MODE_NORMAL;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         level_q <= PCS_LEVEL_NONE;
      end else if (supply_fault_error) begin
         level_q <= PCS_LEVEL_NONE;
      end else if (severe_error) begin
         level_q <= PCS_LEVEL_FIRE;
      end else begin
         level_q <= PCS_LEVEL_FULL;
      end
   end

   // ==========================================================
   // Request acceptance
   pcs_state_type state_q;
   pcs_status_type status_q;
   logic armed_q, start_req, speed_ok, deny;
   logic [15:0] count_q;
   assign speed_ok = ~shaft_speed_low_error;
   assign start_req = commissioning_mode & command_q & armed_q & (state_q == PCS_IDLE);

   always_comb begin
      case (req_q.kind)
         PCS_ACT_FIRE: deny = level_q == PCS_LEVEL_NONE;
         PCS_ACT_PUMP: deny = level_q != PCS_LEVEL_FULL || !speed_ok
            || req_q.value < PCS_STROKES_MIN || req_q.value > PCS_STROKES_MAX;
         PCS_ACT_CONFIG: deny = 32'(req_q.value) >= NUM_CONFIGS;
         PCS_ACT_RAW1: deny = level_q != PCS_LEVEL_FULL || !speed_ok;
         PCS_ACT_RAW2: deny = level_q != PCS_LEVEL_FULL || !speed_ok || NUM_SERVICES < 2;
         PCS_ACT_RAW3: deny = level_q != PCS_LEVEL_FULL || !speed_ok || NUM_SERVICES < 3;
         default: deny = 1'b1;
      endcase
   end

   // The host must drop the command before another action is taken
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         armed_q <= 1'b1;
      end else if (start_req) begin
         armed_q <= 1'b0;
      end else if (!command_q && state_q == PCS_IDLE) begin
         armed_q <= 1'b1;
      end
   end

   // ==========================================================
   // Action sequencer
   logic raw_keep;
   assign raw_keep = command_q & speed_ok & (level_q == PCS_LEVEL_FULL);

   always_ff @(posedge clk) begin
      if (!reset_n || power_up) begin
         state_q <= PCS_IDLE;
         status_q <= '0;
         count_q <= '0;
         coil_drive <= '0;
         raw_service_active <= '0;
         output1_displacement_reference <= '0;
      end else begin
         case (state_q)
            PCS_IDLE: begin
               coil_drive <= '0;
               if (start_req && deny) begin
                  status_q <= '{done: 1'b0, in_progress: 1'b0, denied: 1'b1};
               end else if (start_req) begin
                  status_q <= '{done: 1'b0, in_progress: 1'b1, denied: 1'b0};
                  case (req_q.kind)
                     PCS_ACT_FIRE: begin
                        state_q <= PCS_FIRE;
                        coil_drive <= coil_map(req_q.mask);
                        count_q <= 16'(FIRE_CYCLES - 1);
                     end
                     PCS_ACT_PUMP: begin
                        state_q <= PCS_PUMP;
                        count_q <= req_q.value;
                     end
                     PCS_ACT_CONFIG: begin
                        // Done at once, so in progress is never seen
                        status_q <= '{done: 1'b1, in_progress: 1'b0, denied: 1'b0};
                     end
                     default: begin
                        state_q <= PCS_RAW;
                        raw_service_active <= 3'(1) << (req_q.kind - PCS_ACT_RAW1);
                        output1_displacement_reference <= req_q.value;
                     end
                  endcase
               end
            end
            PCS_FIRE: begin
               if (count_q == 16'h0) begin
                  coil_drive <= '0;
                  state_q <= PCS_IDLE;
                  status_q <= '{done: 1'b1, in_progress: 1'b0, denied: 1'b0};
               end else begin
                  count_q <= count_q - 16'h1;
               end
            end
            PCS_PUMP: begin
               // One stroke per pumping-angle pulse; losing speed ends it early
               if (count_q == 16'h0 || !speed_ok || level_q != PCS_LEVEL_FULL) begin
                  coil_drive <= '0;
                  state_q <= PCS_IDLE;
                  status_q <= '{done: 1'b1, in_progress: 1'b0, denied: 1'b0};
               end else if (stroke_angle) begin
                  coil_drive <= coil_map(req_q.mask);
                  count_q <= count_q - 16'h1;
               end else begin
                  coil_drive <= '0;
               end
            end
            PCS_RAW: begin
               if (!raw_keep) begin
                  raw_service_active <= '0;
                  output1_displacement_reference <= '0;
                  state_q <= PCS_IDLE;
                  status_q <= '{done: 1'b1, in_progress: 1'b0, denied: 1'b0};
               end
            end
            default: state_q <= PCS_IDLE;
         endcase
      end
   end

   // Raw displacement always runs on this stored index, whatever the source
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         current_config_index <= '0;
      end else if (start_req && !deny && req_q.kind == PCS_ACT_CONFIG) begin
         current_config_index <= req_q.value[7:0];
      end
   end

   // ==========================================================
   // AXI4-Lite read channel
   logic [31:0] rdata_d;
   logic ar_hs;
   assign ar_hs = s_axi_arvalid & s_axi_arready;

   always_comb begin
      rdata_d = '0;
      case (s_axi_araddr)
         PCS_REG_ENABLE: rdata_d[0] = enable_q;
         PCS_REG_MODE: rdata_d[1:0] = mode_q;
         PCS_REG_ACTION: rdata_d[2:0] = req_q.kind;
         PCS_REG_MASK: rdata_d[11:0] = req_q.mask;
         PCS_REG_VALUE: rdata_d[15:0] = req_q.value;
         PCS_REG_COMMAND: rdata_d[0] = command_q;
         PCS_REG_LEVEL: rdata_d[1:0] = level_q;
         PCS_REG_STATUS: rdata_d[2:0] = status_q;
         PCS_REG_CONFIG: rdata_d[7:0] = current_config_index;
         PCS_REG_CONFIG_SRC: rdata_d[0] = config_src_q;
         default: rdata_d = '0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= PCS_RESP_OKAY;
      end else begin
         s_axi_rvalid <= (s_axi_rvalid & ~s_axi_rready) | ar_hs;
         s_axi_arready <= ~((s_axi_rvalid & ~s_axi_rready) | ar_hs);
         if (ar_hs) begin
            s_axi_rdata <= rdata_d;
            s_axi_rresp <= reg_known(s_axi_araddr) ? PCS_RESP_OKAY : PCS_RESP_SLVERR;
         end
      end
   end

   // ==========================================================
   // Assertions
   a_mode_latch: assert property (@(posedge clk) disable iff (!reset_n)
      power_up |=> commissioning_mode == $past(enable_q)) else $error("mode not latched at power-up");
   a_mode_report: assert property (@(posedge clk) disable iff (!reset_n)
      (power_up && enable_q) |=> mode_q == PCS_MODE_COMMISSION) else $error("mode value not 2");
   a_mode_hold: assert property (@(posedge clk) disable iff (!reset_n)
      !power_up |=> $stable(commissioning_mode)) else $error("mode changed while running");
   a_level_zero: assert property (@(posedge clk) disable iff (!reset_n)
      supply_fault_error |=> level_q == PCS_LEVEL_NONE) else $error("level not 0 on supply fault");
   a_level_other: assert property (@(posedge clk) disable iff (!reset_n)
      (!supply_fault_error && severe_error) |=> level_q == PCS_LEVEL_FIRE)
      else $error("level not 1 on severe error");
   a_pump_level: assert property (@(posedge clk) disable iff (!reset_n)
      (start_req && req_q.kind == PCS_ACT_PUMP && level_q != PCS_LEVEL_FULL) |=> status_q.denied)
      else $error("pump not denied at low level");
   a_stroke_range: assert property (@(posedge clk) disable iff (!reset_n)
      (start_req && req_q.kind == PCS_ACT_PUMP && (req_q.value == 16'h0 || req_q.value > 16'h0064))
      |=> status_q.denied && state_q == PCS_IDLE) else $error("bad stroke count accepted");
   a_fire_coils: assert property (@(posedge clk) disable iff (!reset_n || power_up)
      (start_req && req_q.kind == PCS_ACT_FIRE && level_q != PCS_LEVEL_NONE)
      |=> coil_drive == coil_map($past(req_q.mask)) && state_q == PCS_FIRE) else $error("fire coils wrong");
   a_config_store: assert property (@(posedge clk) disable iff (!reset_n)
      (start_req && req_q.kind == PCS_ACT_CONFIG && !deny)
      |=> current_config_index == $past(req_q.value[7:0]) && status_q.done) else $error("config not stored");
   a_rearm_wait: assert property (@(posedge clk) disable iff (!reset_n)
      (!armed_q && state_q == PCS_IDLE && command_q && !power_up) |=> state_q == PCS_IDLE && $stable(status_q))
      else $error("action restarted without command release");
endmodule : pcs_sequencer
`default_nettype wire

// ---- common/pcs_pkg.sv ----
// Package for the pump commissioning sequencer: register map, codes, timing.
// Assumes a 250 MHz clock and a 32-bit AXI4-Lite register bus.
package pcs_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] PCS_REG_ENABLE = 8'h00;
   localparam logic [7:0] PCS_REG_MODE = 8'h04;
   localparam logic [7:0] PCS_REG_ACTION = 8'h08;
   localparam logic [7:0] PCS_REG_MASK = 8'h0C;
   localparam logic [7:0] PCS_REG_VALUE = 8'h10;
   localparam logic [7:0] PCS_REG_COMMAND = 8'h14;
   localparam logic [7:0] PCS_REG_LEVEL = 8'h18;
   localparam logic [7:0] PCS_REG_STATUS = 8'h1C;
   localparam logic [7:0] PCS_REG_CONFIG = 8'h20;
   localparam logic [7:0] PCS_REG_CONFIG_SRC = 8'h24;
   // ==========================================================
   // Field values
   localparam logic [1:0] PCS_MODE_NORMAL = 2'h0;
   localparam logic [1:0] PCS_MODE_COMMISSION = 2'h2;
   localparam logic [1:0] PCS_LEVEL_NONE = 2'h0;
   localparam logic [1:0] PCS_LEVEL_FIRE = 2'h1;
   localparam logic [1:0] PCS_LEVEL_FULL = 2'h2;
   localparam logic [2:0] PCS_ACT_FIRE = 3'h1;
   localparam logic [2:0] PCS_ACT_PUMP = 3'h2;
   localparam logic [2:0] PCS_ACT_CONFIG = 3'h3;
   localparam logic [2:0] PCS_ACT_RAW1 = 3'h4;
   localparam logic [2:0] PCS_ACT_RAW2 = 3'h5;
   localparam logic [2:0] PCS_ACT_RAW3 = 3'h6;
   localparam logic [15:0] PCS_STROKES_MIN = 16'h0001;
   localparam logic [15:0] PCS_STROKES_MAX = 16'h0064;
   localparam int PCS_COILS = 12;
   localparam int PCS_GROUPS = 3;
   localparam int PCS_UNITS = 4;
   localparam logic [1:0] PCS_RESP_OKAY = 2'h0;
   localparam logic [1:0] PCS_RESP_SLVERR = 2'h2;
   localparam logic [31:0] PCS_RESET_WORD = 32'h0000_0000;
   // ==========================================================
   // Timing
   localparam int PCS_CLK_PERIOD_NS = 4;
   localparam int PCS_FIRE_TIME_NS = 1000;
   localparam int PCS_FIRE_CYCLES = (PCS_FIRE_TIME_NS + PCS_CLK_PERIOD_NS - 1) / PCS_CLK_PERIOD_NS;
   // ==========================================================
   // Types
   typedef struct packed {
      logic done;
      logic in_progress;
      logic denied;
   } pcs_status_type;
   typedef struct packed {
      logic [2:0] kind;
      logic [11:0] mask;
      logic [15:0] value;
   } pcs_request_type;
   typedef enum logic [1:0] {PCS_IDLE, PCS_FIRE, PCS_PUMP, PCS_RAW} pcs_state_type;
endpackage : pcs_pkg

// ---- tb/pcs_host_model.sv ----
// Service host model: an AXI4-Lite master that runs one register access at a time.
// Assumes the bench calls write and read in sequence; hung counts waits that ran out.
`timescale 1ns/100ps
`default_nettype none
module pcs_host_model (
   input wire logic clk,
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   int hung = 0;
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
   end
   // ==========================================================
   // Bus cycles
   // Parameters are written one word at a time, so the caller fixes their order
   task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end while (!bvalid && n < 500);
      if (!bvalid) hung++;
      r = bresp;
      bready <= 1'b0;
   endtask : write
   task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         n++;
      end while (!rvalid && n < 500);
      if (!rvalid) hung++;
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : read
endmodule : pcs_host_model
`default_nettype wire

// ---- tb/pump_commissioning_sequencer_tb.sv ----
// Self-checking bench for the commissioning sequencer, seeded random masks and values.
// Assumes pcs_pkg is compiled first and the host model drives the register bus.
`timescale 1ns/100ps
`default_nettype none
module pump_commissioning_sequencer_tb
   import pcs_pkg::*;
();
   logic clk, reset_n, power_up, supply_fault_error, severe_error, shaft_speed_low_error, stroke_angle;
   logic [7:0] awaddr, araddr, current_config_index;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, commissioning_mode;
   logic [31:0] wdata, rdata, rdv;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rsp;
   logic [11:0] coil_drive, m;
   logic [2:0] raw_service_active;
   logic [15:0] output1_displacement_reference, v;
   int failures = 0, check_count = 0, seed = 60, hits, i, k;
   pcs_sequencer #(.FIRE_CYCLES(16)) pcs_sequencer_i (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .power_up(power_up), .supply_fault_error(supply_fault_error), .severe_error(severe_error),
      .shaft_speed_low_error(shaft_speed_low_error), .stroke_angle(stroke_angle),
      .commissioning_mode(commissioning_mode), .coil_drive(coil_drive), .raw_service_active(raw_service_active),
      .output1_displacement_reference(output1_displacement_reference), .current_config_index(current_config_index));
   pcs_host_model pcs_host_model_i (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ==========================================================
   // Helpers
   task results;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      pcs_host_model_i.write(a, d, rsp);
      if (pcs_host_model_i.hung != 0) begin
         failures++;
         results();
      end
   endtask : wr
   task rd(input logic [7:0] a);
      pcs_host_model_i.read(a, rdv, rsp);
      if (pcs_host_model_i.hung != 0) begin
         failures++;
         results();
      end
   endtask : rd
   function automatic logic [11:0] map_mask(input logic [11:0] mk);
      logic [11:0] c;
      c = 12'h000;
      for (int g = 0; g < 3; g++) for (int u = 0; u < 4; u++) c[u*3+g] = mk[g*4+u];
      return c;
   endfunction : map_mask
   task act(input logic [2:0] t, input logic [11:0] mk, input logic [15:0] val);
      wr(PCS_REG_ACTION, 32'(t));
      wr(PCS_REG_MASK, 32'(mk));
      wr(PCS_REG_VALUE, 32'(val));
      wr(PCS_REG_COMMAND, 32'h1);
   endtask : act
   task fin;
      wr(PCS_REG_COMMAND, 32'h0);
   endtask : fin
   task status(input logic [2:0] e);
      rd(PCS_REG_STATUS);
      chk("status", rdv, 32'(e));
   endtask : status
   task wait_coils(input logic on);
      int n;
      n = 0;
      while ((|coil_drive) !== on && n < 100) begin
         @(posedge clk);
         n++;
      end
      if (n == 100) begin
         failures++;
         results();
      end
   endtask : wait_coils
   task pwr;
      @(posedge clk) power_up <= 1'b1;
      @(posedge clk) power_up <= 1'b0;
   endtask : pwr
   task set_in(input logic sf, input logic se, input logic sl);
      @(posedge clk);
      supply_fault_error <= sf;
      severe_error <= se;
      shaft_speed_low_error <= sl;
   endtask : set_in
   // ==========================================================
   // Main sequence
   initial begin
      {reset_n, power_up, supply_fault_error, severe_error, shaft_speed_low_error, stroke_angle} = '0;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      wr(PCS_REG_ENABLE, 32'h1);
      rd(PCS_REG_MODE);
      chk("mode before power cycle", rdv, 32'h0);
      pwr();
      rd(PCS_REG_MODE);
      chk("mode", rdv, 32'(PCS_MODE_COMMISSION));
      chk("mode pin", 32'(commissioning_mode), 32'h1);
      rd(8'h28);
      chk("unmapped read", {rdv[29:0], rsp}, 32'(PCS_RESP_SLVERR));
      wr(8'h02, 32'h1);
      chk("unaligned write", 32'(rsp), 32'(PCS_RESP_SLVERR));
      for (i = 0; i < 4; i++) begin
         set_in(i[1], i[0], 1'b0);
         rd(PCS_REG_LEVEL);
         chk("level", rdv, i[1] ? 32'h0 : (i[0] ? 32'h1 : 32'h2));
      end
      set_in(1'b1, 1'b0, 1'b0);
      act(PCS_ACT_FIRE, 12'hFFF, 16'h0000);
      status(3'h1);
      chk("coils denied", 32'(coil_drive), 32'h0);
      fin();
      for (i = 0; i < 6; i++) begin
         m = (i < 3) ? ((i == 0) ? 12'hFFF : 12'h001 << (i * 4)) : 12'($random(seed));
         if (m == 12'h000) m = 12'h001;
         set_in(1'b0, i[0], 1'b1);
         act(PCS_ACT_FIRE, m, 16'h0000);
         wait_coils(1'b1);
         chk("fire coils", 32'(coil_drive), 32'(map_mask(m)));
         status(3'h2);
         wait_coils(1'b0);
         status(3'h4);
         repeat (10) @(posedge clk);
         chk("no rerun", 32'(coil_drive), 32'h0);
         fin();
      end
      m = 12'h111;
      for (i = 0; i < 4; i++) begin
         set_in(1'b0, i == 3, i == 2);
         act(PCS_ACT_PUMP, m, (i == 0) ? 16'h0000 : ((i == 1) ? 16'h0065 : 16'h0005));
         status(3'h1);
         fin();
      end
      set_in(1'b0, 1'b0, 1'b0);
      for (k = 0; k < 2; k++) begin
         v = k ? 16'h0064 : 16'h0001;
         act(PCS_ACT_PUMP, m, v);
         hits = 0;
         for (i = 0; i <= v; i++) begin
            @(posedge clk) stroke_angle <= 1'b1;
            @(posedge clk) stroke_angle <= 1'b0;
            repeat (3) begin
               @(posedge clk);
               if (coil_drive === map_mask(m)) hits++;
            end
         end
         chk("strokes", hits, 32'(v));
         status(3'h4);
         fin();
      end
      set_in(1'b1, 1'b0, 1'b1);
      wr(PCS_REG_CONFIG_SRC, 32'h1);
      act(PCS_ACT_CONFIG, 12'h000, 16'h0002);
      rd(PCS_REG_CONFIG);
      chk("config", rdv, 32'h2);
      chk("config pin", 32'(current_config_index), 32'h2);
      status(3'h4);
      fin();
      act(PCS_ACT_CONFIG, 12'h000, 16'h0004);
      status(3'h1);
      fin();
      act(3'h7, 12'h000, 16'h0000);
      status(3'h1);
      fin();
      set_in(1'b0, 1'b0, 1'b0);
      for (k = 0; k < 3; k++) begin
         v = 16'($random(seed));
         act(PCS_ACT_RAW1 + 3'(k), 12'h000, v);
         repeat (3) @(posedge clk);
         chk("raw service", 32'(raw_service_active), 32'h1 << k);
         chk("raw value", 32'(output1_displacement_reference), 32'(v));
         chk("raw config", 32'(current_config_index), 32'h2);
         fin();
         repeat (3) @(posedge clk);
         chk("raw stop", 32'(raw_service_active), 32'h0);
         status(3'h4);
      end
      set_in(1'b0, 1'b0, 1'b1);
      act(PCS_ACT_RAW1, 12'h000, 16'h0010);
      status(3'h1);
      fin();
      wr(PCS_REG_ENABLE, 32'h0);
      pwr();
      rd(PCS_REG_MODE);
      chk("mode after exit", rdv, 32'(PCS_MODE_NORMAL));
      chk("mode pin exit", 32'(commissioning_mode), 32'h0);
      results();
   end
endmodule : pump_commissioning_sequencer_tb
`default_nettype wire
